/* File: hdl/synth_ctl_pkg.sv */
// shared constants for the synthesizer loop control link
package synth_ctl_pkg;
    localparam int TEST_W = 20;
    localparam int SPD_W = 8;
    localparam int SPD_FIELD_W = 4;
    localparam logic [3:0] SPD_LOW_FILL = 4'hF;
    localparam logic [19:0] TEST_NORMAL = 20'h00000;
    localparam logic [19:0] TEST_FRAC_OVF = 20'h00004;
    localparam logic [19:0] TEST_AUX_DIV = 20'h00005;
    localparam logic [19:0] TEST_MAIN_DIV = 20'h00006;
    localparam logic [19:0] TEST_MAIN_REF = 20'h00007;
    localparam logic [19:0] TEST_FORCE_HI = 20'hC0000;
    localparam logic [19:0] TEST_FORCE_LO = 20'h40000;
    localparam logic [19:0] TEST_PUMP_UP = 20'h000A8;
    localparam logic [19:0] TEST_PUMP_DN = 20'h00058;
    localparam logic [19:0] TEST_FRAC_PUMP = 20'h00200;
    localparam logic [19:0] TEST_MAIN_BYP = 20'h00106;
    localparam logic [19:0] TEST_AUX_BYP = 20'h08005;
    localparam logic [19:0] TEST_REF_CHAIN = 20'h10007;
endpackage

/* File: hdl/synth_ctl_if.sv */
// link between baseband controller and synthesizer control logic
`timescale 1ns/1ps
`default_nettype none
interface synth_ctl_if;
    logic strobe;
    logic tx_on_input;
    logic word_a_wr;
    logic word_b_wr;
    logic word_d_wr;
    logic word_e_wr;
    logic main_loop_on;
    logic aux_loop_on;
    logic secondary_scheme;
    logic [3:0] spd_field;
    logic [19:0] test_select_bits;
    logic lock_out;
    modport dev (
        input strobe, tx_on_input, word_a_wr, word_b_wr, word_d_wr, word_e_wr,
        input main_loop_on, aux_loop_on, secondary_scheme, spd_field, test_select_bits,
        output lock_out
    );
    modport ctl (
        output strobe, tx_on_input, word_a_wr, word_b_wr, word_d_wr, word_e_wr,
        output main_loop_on, aux_loop_on, secondary_scheme, spd_field, test_select_bits,
        input lock_out
    );
endinterface
`default_nettype wire

/* File: hdl/synth_loop_control_logic.sv */
// device end: loop power gating, speed-up timing, lock mux, if enable circuit
// Operation
// R1: main and aux loops enabled independently
// R2: disabled loop: input stages and pump bias off
// R3: both disabled: reference stage off too
// R4: word loading independent of reference chain
// R5: speed-up raises proportional, enables integral pump
// R6: secondary speed-up lasts count reference periods
// R7: count is field upper nibble, low ones
// R8: default scheme speed-up follows strobe after word
// R9: lock is AND of three qualified terms
// R10: test mode drives lock from internal node
// R11: test word write loads 20-bit selection
// R12: all-zero test field means normal lock
// R13: fourth word write clears test bits
// R14: low nibble codes route divider nodes
// R15: top nibble forces lock high or low
// R16: low byte codes force both pumps up/down
// R17: decode prescaler bypass, frac and ref tests
// R18: strobe fall sets if enable flip-flop
// R19: tx enable turns on modulator and amplifier
// R20: tx enable rise leaves if enable alone
// R21: tx enable fall clears if enable
// R22: standby forces if lock flag locked
// R23: timer counts reference pulses, ends at count
// R24: next strobe fall releases second flip-flop
`timescale 1ns/1ps
`default_nettype none
module synth_loop_control_logic (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // controller link
    synth_ctl_if.dev link,
    // analog-side status
    input wire logic main_phase_held,
    input wire logic aux_phase_held,
    input wire logic if_phase_held,
    input wire logic standby,
    input wire logic ref_div_pulse,
    input wire logic frac_overflow,
    input wire logic aux_div_out,
    input wire logic main_div_out,
    input wire logic main_ref_div_out,
    // power and mode controls
    output logic main_stage_on,
    output logic aux_stage_on,
    output logic ref_stage_on,
    output logic proportional_pump_out,
    output logic integral_pump_out,
    output logic pump_force_up,
    output logic pump_force_dn,
    output logic frac_pump_test,
    output logic main_presc_bypass,
    output logic aux_presc_bypass,
    output logic ref_chain_test,
    output logic if_chain_on,
    output logic mod_amp_on
);
    logic strobe_prev_reg;
    logic tx_prev_reg;
    logic [4:0] stat_sync1_reg;
    logic [4:0] stat_sync2_reg;
    logic [3:0] node_sync1_reg;
    logic [3:0] node_sync2_reg;
    logic ref_prev_reg;
    logic [19:0] test_reg;
    logic [7:0] spd_count_reg;
    logic [7:0] spd_limit_reg;
    logic spd_run_reg;
    logic a_pending_reg;
    logic spd_strobe_reg;
    logic ff2_nq_reg;
    logic if_en_reg;
    logic lock_reg;
    logic strobe_s, strobe_fall, tx_s, tx_fall, ref_rise;
    logic lock_comb;
    function automatic logic code_is(input logic [19:0] t, input logic [19:0] c);
        code_is = (t == c);
    endfunction
    assign strobe_s = link.strobe;
    assign strobe_fall = strobe_prev_reg & ~link.strobe;
    assign tx_s = link.tx_on_input;
    assign tx_fall = tx_prev_reg & ~link.tx_on_input;
    assign ref_rise = stat_sync2_reg[4] & ~ref_prev_reg;
    // status synchronisers, link edge history; word loading uses only sys_clk [R4]
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strobe_prev_reg <= 1'b0;
            tx_prev_reg <= 1'b0;
            stat_sync1_reg <= 5'h00;
            stat_sync2_reg <= 5'h00;
            node_sync1_reg <= 4'h0;
            node_sync2_reg <= 4'h0;
            ref_prev_reg <= 1'b0;
        end
        else
        begin
            strobe_prev_reg <= link.strobe;
            tx_prev_reg <= link.tx_on_input;
            stat_sync1_reg <= {ref_div_pulse, standby, if_phase_held, aux_phase_held,
                               main_phase_held};
            stat_sync2_reg <= stat_sync1_reg;
            node_sync1_reg <= {main_ref_div_out, main_div_out, aux_div_out, frac_overflow};
            node_sync2_reg <= node_sync1_reg;
            ref_prev_reg <= stat_sync2_reg[4];
        end
    end
    // test selection register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            test_reg <= synth_ctl_pkg::TEST_NORMAL;
        else if (link.word_d_wr)
            test_reg <= synth_ctl_pkg::TEST_NORMAL; // [R13]
        else if (link.word_e_wr)
            test_reg <= link.test_select_bits; // [R11] [R12]
    end
    // loop power gating
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            main_stage_on <= 1'b0;
            aux_stage_on <= 1'b0;
            ref_stage_on <= 1'b0;
        end
        else
        begin
            main_stage_on <= link.main_loop_on; // [R1] [R2]
            aux_stage_on <= link.aux_loop_on; // [R1] [R2]
            ref_stage_on <= link.main_loop_on | link.aux_loop_on; // [R3]
        end
    end
    // secondary scheme speed-up timer
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            spd_run_reg <= 1'b0;
            spd_count_reg <= 8'h00;
            spd_limit_reg <= 8'h00;
        end
        else if (link.secondary_scheme && link.word_b_wr)
        begin
            spd_run_reg <= 1'b1;
            spd_count_reg <= 8'h00;
            spd_limit_reg <= {link.spd_field, synth_ctl_pkg::SPD_LOW_FILL}; // [R7]
        end
        else if (spd_run_reg && ref_rise)
        begin
            spd_count_reg <= spd_count_reg + 8'h01; // [R23]
            if (spd_count_reg + 8'h01 == spd_limit_reg)
                spd_run_reg <= 1'b0; // [R6]
        end
    end
    // default scheme: strobe after first word holds speed-up
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            a_pending_reg <= 1'b0;
            spd_strobe_reg <= 1'b0;
        end
        else
        begin
            if (link.word_a_wr && !link.secondary_scheme && !strobe_s)
                a_pending_reg <= 1'b1;
            else if (strobe_s)
                a_pending_reg <= 1'b0;
            if ((a_pending_reg || (link.word_a_wr && !link.secondary_scheme)) && strobe_s)
                spd_strobe_reg <= 1'b1; // [R8]
            else if (!strobe_s)
                spd_strobe_reg <= 1'b0; // [R8]
        end
    end
    // pump currents and forced test pump states
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            proportional_pump_out <= 1'b0;
            integral_pump_out <= 1'b0;
            pump_force_up <= 1'b0;
            pump_force_dn <= 1'b0;
            frac_pump_test <= 1'b0;
            main_presc_bypass <= 1'b0;
            aux_presc_bypass <= 1'b0;
            ref_chain_test <= 1'b0;
        end
        else
        begin
            proportional_pump_out <= spd_run_reg | spd_strobe_reg; // [R5]
            integral_pump_out <= spd_run_reg | spd_strobe_reg; // [R5]
            pump_force_up <= code_is(test_reg, synth_ctl_pkg::TEST_PUMP_UP); // [R16]
            pump_force_dn <= code_is(test_reg, synth_ctl_pkg::TEST_PUMP_DN); // [R16]
            frac_pump_test <= code_is(test_reg, synth_ctl_pkg::TEST_FRAC_PUMP); // [R17]
            main_presc_bypass <= code_is(test_reg, synth_ctl_pkg::TEST_MAIN_BYP); // [R17]
            aux_presc_bypass <= code_is(test_reg, synth_ctl_pkg::TEST_AUX_BYP); // [R17]
            ref_chain_test <= code_is(test_reg, synth_ctl_pkg::TEST_REF_CHAIN); // [R17]
        end
    end
    // if synthesizer enable circuit: two flip-flops
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ff2_nq_reg <= 1'b1;
            if_en_reg <= 1'b0;
        end
        else
        begin
            if (tx_fall)
                ff2_nq_reg <= 1'b0; // [R21]
            else if (strobe_fall)
                ff2_nq_reg <= 1'b1; // [R24]
            if (tx_fall || !ff2_nq_reg)
                if_en_reg <= 1'b0; // [R21] [R20]
            else if (strobe_fall)
                if_en_reg <= 1'b1; // [R18]
        end
    end
    // lock combine and test routing
    always_comb
    begin
        lock_comb = (stat_sync2_reg[0] | ~main_stage_on)
                  & (stat_sync2_reg[1] | ~aux_stage_on)
                  & (stat_sync2_reg[2] | stat_sync2_reg[3] | ~if_en_reg); // [R9] [R22]
        case (test_reg)
            synth_ctl_pkg::TEST_NORMAL: lock_comb = lock_comb; // [R12]
            synth_ctl_pkg::TEST_FRAC_OVF: lock_comb = node_sync2_reg[0]; // [R14] [R10]
            synth_ctl_pkg::TEST_AUX_DIV: lock_comb = node_sync2_reg[1]; // [R14]
            synth_ctl_pkg::TEST_MAIN_DIV: lock_comb = node_sync2_reg[2]; // [R14]
            synth_ctl_pkg::TEST_MAIN_REF: lock_comb = node_sync2_reg[3]; // [R14]
            synth_ctl_pkg::TEST_FORCE_HI: lock_comb = 1'b1; // [R15]
            synth_ctl_pkg::TEST_FORCE_LO: lock_comb = 1'b0; // [R15]
            default: lock_comb = 1'b0;
        endcase
    end
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_reg <= 1'b0;
            if_chain_on <= 1'b0;
            mod_amp_on <= 1'b0;
        end
        else
        begin
            lock_reg <= lock_comb;
            if_chain_on <= if_en_reg & ~tx_fall; // [R18]
            mod_amp_on <= tx_s & if_en_reg & ~tx_fall; // [R19]
        end
    end
    assign link.lock_out = lock_reg;
endmodule
`default_nettype wire

/* File: hdl/synth_ctl_master.sv */
// controller end: sequences word writes, strobe and transmit enable
`timescale 1ns/1ps
`default_nettype none
module synth_ctl_master (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // user requests
    input wire logic wr_req,
    input wire logic [1:0] wr_word,
    input wire logic [19:0] wr_data,
    input wire logic strobe_hold,
    input wire logic tx_req,
    // user status
    output logic busy,
    output logic lock_seen,
    // controller link
    synth_ctl_if.ctl link
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_STROBE = 3'b100
    } state_t;
    state_t state_reg;
    logic [1:0] word_reg;
    logic [19:0] data_reg;
    logic strobe_reg, tx_reg, wa_reg, wb_reg, wd_reg, we_reg;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_IDLE;
            word_reg <= 2'h0;
            data_reg <= 20'h00000;
            strobe_reg <= 1'b0;
            wa_reg <= 1'b0;
            wb_reg <= 1'b0;
            wd_reg <= 1'b0;
            we_reg <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            wa_reg <= 1'b0;
            wb_reg <= 1'b0;
            wd_reg <= 1'b0;
            we_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                    if (wr_req)
                    begin
                        word_reg <= wr_word;
                        data_reg <= wr_data;
                        busy <= 1'b1;
                        state_reg <= ST_WRITE;
                    end
                ST_WRITE:
                begin
                    wa_reg <= (word_reg == 2'h0);
                    wb_reg <= (word_reg == 2'h1);
                    wd_reg <= (word_reg == 2'h2);
                    we_reg <= (word_reg == 2'h3); // [R11] [R12]
                    strobe_reg <= 1'b1;
                    state_reg <= ST_STROBE;
                end
                ST_STROBE:
                    if (!strobe_hold)
                    begin
                        strobe_reg <= 1'b0; // [R8]
                        busy <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    // transmit enable only once lock has been seen
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_reg <= 1'b0;
            lock_seen <= 1'b0;
        end
        else
        begin
            lock_seen <= link.lock_out;
            tx_reg <= tx_req & (tx_reg | link.lock_out); // [R19]
        end
    end
    assign link.strobe = strobe_reg;
    assign link.tx_on_input = tx_reg;
    assign link.word_a_wr = wa_reg;
    assign link.word_b_wr = wb_reg;
    assign link.word_d_wr = wd_reg;
    assign link.word_e_wr = we_reg;
    assign link.main_loop_on = data_reg[0];
    assign link.aux_loop_on = data_reg[1];
    assign link.secondary_scheme = data_reg[2];
    assign link.spd_field = data_reg[7:4];
    assign link.test_select_bits = data_reg;
endmodule
`default_nettype wire

/* File: testbench/synth_ctl_properties.sv */
// concurrent checks on the controller to device link
`timescale 1ns/1ps
`default_nettype none
module synth_ctl_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // link signals
    input wire logic strobe,
    input wire logic tx_on_input,
    input wire logic word_a_wr,
    input wire logic word_b_wr,
    input wire logic word_d_wr,
    input wire logic word_e_wr,
    input wire logic [19:0] test_select_bits,
    input wire logic lock_out
);
    wire logic wr_any;
    assign wr_any = word_a_wr | word_b_wr | word_d_wr | word_e_wr;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    a_strobe_with_write: assert property (wr_any |-> ##[0:1] strobe)
        else $error("strobe missing after word write");
    a_strobe_cause: assert property ($rose(strobe) |-> wr_any || $past(wr_any))
        else $error("strobe rose without a word write");
    a_pulse_single: assert property (wr_any |=> !wr_any)
        else $error("word write pulse longer than one cycle");
    a_word_onehot: assert property ($onehot0({word_a_wr, word_b_wr, word_d_wr, word_e_wr}))
        else $error("two word writes at once");
    a_force_high: assert property (word_e_wr && test_select_bits == synth_ctl_pkg::TEST_FORCE_HI
        |-> ##[1:4] lock_out)
        else $error("lock not forced high");
    a_force_low: assert property (word_e_wr && test_select_bits == synth_ctl_pkg::TEST_FORCE_LO
        |-> ##[1:4] !lock_out)
        else $error("lock not forced low");
    a_force_hold: assert property ((word_e_wr && test_select_bits == synth_ctl_pkg::TEST_FORCE_HI)
        ##1 (!wr_any) [*4] |-> lock_out)
        else $error("forced high lock not held");
    a_tx_after_lock: assert property ($rose(tx_on_input)
        |-> $past(lock_out) || $past(lock_out, 2) || $past(lock_out, 3))
        else $error("transmit enable raised before lock");
    c_test_word: cover property (word_e_wr);
    c_tx_rise: cover property ($rose(tx_on_input));
    c_tx_fall: cover property ($fell(tx_on_input));
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench: controller end and device end joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic wr_req = 1'b0;
    logic [1:0] wr_word = 2'h0;
    logic [19:0] wr_data = 20'h00000;
    logic strobe_hold = 1'b0;
    logic tx_req = 1'b0;
    logic [3:0] held = 4'h7; // main, aux, if, standby
    logic [3:0] node = 4'h0; // frac ovf, aux div, main div, main ref
    logic ref_pulse = 1'b0;
    logic [15:0] lfsr = 16'h0062;
    int error_cnt = 0;
    int n_tests = 0;
    wire logic busy;
    wire logic lock_seen;
    wire logic [12:0] dev_out;
    synth_ctl_if link ();
    synth_ctl_master i_synth_ctl_master (.sys_clk(sys_clk), .arst_n(arst_n), .wr_req(wr_req),
        .wr_word(wr_word), .wr_data(wr_data), .strobe_hold(strobe_hold), .tx_req(tx_req),
        .busy(busy), .lock_seen(lock_seen), .link(link.ctl));
    synth_loop_control_logic i_synth_loop_control_logic (.sys_clk(sys_clk), .arst_n(arst_n),
        .link(link.dev), .main_phase_held(held[0]), .aux_phase_held(held[1]),
        .if_phase_held(held[2]), .standby(held[3]), .ref_div_pulse(ref_pulse),
        .frac_overflow(node[0]), .aux_div_out(node[1]), .main_div_out(node[2]),
        .main_ref_div_out(node[3]), .main_stage_on(dev_out[12]), .aux_stage_on(dev_out[11]),
        .ref_stage_on(dev_out[10]), .proportional_pump_out(dev_out[9]),
        .integral_pump_out(dev_out[8]), .pump_force_up(dev_out[7]), .pump_force_dn(dev_out[6]),
        .frac_pump_test(dev_out[5]), .main_presc_bypass(dev_out[4]),
        .aux_presc_bypass(dev_out[3]), .ref_chain_test(dev_out[2]), .if_chain_on(dev_out[1]),
        .mod_amp_on(dev_out[0]));
    synth_ctl_properties i_props (.sys_clk(sys_clk), .arst_n(arst_n), .strobe(link.strobe),
        .tx_on_input(link.tx_on_input), .word_a_wr(link.word_a_wr), .word_b_wr(link.word_b_wr),
        .word_d_wr(link.word_d_wr), .word_e_wr(link.word_e_wr),
        .test_select_bits(link.test_select_bits), .lock_out(link.lock_out));
    localparam logic [19:0] MUX_CODE [4] = '{synth_ctl_pkg::TEST_FRAC_OVF,
        synth_ctl_pkg::TEST_AUX_DIV, synth_ctl_pkg::TEST_MAIN_DIV, synth_ctl_pkg::TEST_MAIN_REF};
    localparam logic [19:0] MODE_CODE [6] = '{synth_ctl_pkg::TEST_PUMP_UP,
        synth_ctl_pkg::TEST_PUMP_DN, synth_ctl_pkg::TEST_FRAC_PUMP, synth_ctl_pkg::TEST_MAIN_BYP,
        synth_ctl_pkg::TEST_AUX_BYP, synth_ctl_pkg::TEST_REF_CHAIN};
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [2:0] exp_power(input logic [1:0] loops);
        return {loops[0], loops[1], loops[0] | loops[1]};
    endfunction
    function automatic logic exp_lock(input logic [3:0] h, input logic [1:0] loops);
        return (h[0] | ~loops[0]) & (h[1] | ~loops[1]) & (h[2] | h[3]);
    endfunction
    task automatic check_val(input logic [12:0] got, input logic [12:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic send_word(input logic [1:0] w, input logic [19:0] d);
        int k;
        @(negedge sys_clk);
        wr_word = w;
        wr_data = d;
        wr_req = 1'b1;
        @(negedge sys_clk);
        wr_req = 1'b0;
        k = 0;
        while (busy !== 1'b0 && strobe_hold !== 1'b1 && k < 200)
        begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 200)
        begin
            error_cnt++;
            $display("Error at %0t: controller stuck busy", $time);
        end
        settle();
    endtask
    task automatic ref_pulses(input int n);
        repeat (n)
        begin
            ref_pulse = 1'b1;
            repeat (3) @(negedge sys_clk);
            ref_pulse = 1'b0;
            repeat (3) @(negedge sys_clk);
        end
    endtask
    task automatic finish_test();
        $display("Mismatches %0d of %0d comparisons", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #(4 * 40000);
        error_cnt++;
        finish_test();
    end
    initial
    begin
        logic [7:0] cnt;
        repeat (12) @(negedge sys_clk);
        check_val(dev_out, 13'h0000);
        arst_n = 1'b1;
        send_word(2'h2, 20'h00000);
        for (int i = 0; i < 8; i++)
        begin
            lfsr = lfsr_next(lfsr);
            send_word(2'h2, {18'h00000, lfsr[1:0]});
            check_val(dev_out[12:10], exp_power(lfsr[1:0]));
        end
        for (int i = 0; i < 4; i++)
        begin
            lfsr = lfsr_next(lfsr);
            node = lfsr[3:0];
            send_word(2'h3, MUX_CODE[i]);
            check_val(link.lock_out, node[i]);
            node = ~node;
            settle();
            check_val(link.lock_out, node[i]);
        end
        send_word(2'h3, synth_ctl_pkg::TEST_FORCE_LO);
        check_val(link.lock_out, 1'b0);
        send_word(2'h2, 20'h00003);
        check_val(link.lock_out, exp_lock(held, 2'h3));
        held[0] = 1'b0;
        settle();
        check_val(link.lock_out, exp_lock(held, 2'h3));
        send_word(2'h2, 20'h00002);
        check_val(link.lock_out, exp_lock(held, 2'h2));
        held = 4'h0;
        send_word(2'h3, synth_ctl_pkg::TEST_FORCE_HI);
        check_val(link.lock_out, 1'b1);
        held = 4'h7;
        send_word(2'h3, synth_ctl_pkg::TEST_FORCE_LO);
        send_word(2'h3, synth_ctl_pkg::TEST_NORMAL);
        check_val(link.lock_out, exp_lock(held, 2'h0));
        for (int i = 0; i < 6; i++)
        begin
            send_word(2'h3, MODE_CODE[i]);
            check_val(dev_out[7:2], 6'h20 >> i);
        end
        send_word(2'h3, synth_ctl_pkg::TEST_NORMAL);
        check_val(dev_out[7:2], 6'h00);
        for (int f = 0; f < 2; f++)
        begin
            cnt = {f[3:0], synth_ctl_pkg::SPD_LOW_FILL};
            send_word(2'h1, {12'h000, f[3:0], 4'h7});
            check_val(dev_out[9:8], 2'h3);
            ref_pulses(int'(cnt) - 1);
            check_val(dev_out[9:8], 2'h3);
            ref_pulses(2);
            check_val(dev_out[9:8], 2'h0);
        end
        strobe_hold = 1'b1;
        send_word(2'h0, 20'h00003);
        check_val(dev_out[9:8], 2'h3);
        strobe_hold = 1'b0;
        repeat (8) @(negedge sys_clk);
        check_val(dev_out[9:8], 2'h0);
        check_val(dev_out[1], 1'b1);
        held[2] = 1'b0;
        settle();
        check_val(link.lock_out, 1'b0);
        held[3] = 1'b1;
        settle();
        check_val(link.lock_out, 1'b1);
        held = 4'h7;
        settle();
        check_val(lock_seen, 1'b1);
        tx_req = 1'b1;
        repeat (10) @(negedge sys_clk);
        check_val(dev_out[1:0], 2'h3);
        tx_req = 1'b0;
        repeat (10) @(negedge sys_clk);
        check_val(dev_out[1:0], 2'h0);
        send_word(2'h0, 20'h00003);
        check_val(dev_out[1], 1'b0);
        send_word(2'h0, 20'h00003);
        check_val(dev_out[1], 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
